// ---- logic/e1ts_pkg.sv ----
// constants for the e1 timeslot 16, signalling and line code control block
package e1ts_pkg;
   // register addresses on the host port
   localparam logic [7:0] ADDR_TX_TS16_MULTIFRAME_WORD = 8'h13;
   localparam logic [7:0] ADDR_INTERRUPT_SIGNALLING_CONTROL = 8'h14;
   localparam logic [7:0] ADDR_CODING_LOOPBACK_CONTROL = 8'h15;
   // reset values
   localparam logic [7:0] RST_TX_TS16_MULTIFRAME_WORD = 8'h0F;
   localparam logic [7:0] RST_INTERRUPT_SIGNALLING_CONTROL = 8'h00;
   localparam logic [7:0] RST_CODING_LOOPBACK_CONTROL = 8'h00;
   // implemented bits, unused bits read as zero
   localparam logic [7:0] MASK_INTERRUPT_SIGNALLING_CONTROL = 8'hF8;
   localparam logic [7:0] MASK_CODING_LOOPBACK_CONTROL = 8'hE8;
   // multiframe word fields
   localparam int MF_ALIGN_MSB = 7;
   localparam int MF_ALIGN_LSB = 4;
   localparam int MF_SPARE_A = 3;
   localparam int MF_REMOTE_ALARM = 2;
   localparam int MF_SPARE_B = 1;
   localparam int MF_SPARE_C = 0;
   // signalling control fields
   localparam int SIG_DATA_OUT_EN = 7;
   localparam int SIG_STREAM_OUT_EN = 6;
   localparam int SIG_TX_CCS = 5;
   localparam int SIG_FILTER_SEL = 4;
   localparam int SIG_UPPER_NIBBLE = 3;
   // coding and loopback fields
   localparam int CODE_RX_HDB3 = 7;
   localparam int CODE_ANALOG_LOOP = 6;
   localparam int CODE_TX_HDB3 = 5;
   localparam int CODE_DIGITAL_LOOP = 3;
   // frame layout
   localparam logic [4:0] SIG_TIMESLOT = 5'd16;
   localparam logic [3:0] MF_FRAME_ZERO = 4'd0;
   // line rate divider, rates in kHz
   localparam int SYS_CLK_KHZ = 25000;
   localparam int LINE_RATE_KHZ = 2048;
   localparam logic [14:0] DIV_MODULUS = 15'(SYS_CLK_KHZ);
   localparam logic [14:0] DIV_STEP = 15'(LINE_RATE_KHZ);
   // signalling filter, counted in multiframes of 2 ms
   localparam int SIG_FILTER_MS = 14;
   localparam int MULTIFRAME_MS = 2;
   localparam logic [2:0] SIG_FILTER_MF = 3'(SIG_FILTER_MS / MULTIFRAME_MS);
   // line pulse codes inside the encoder delay line
   localparam logic [1:0] PULSE_ZERO = 2'h0;
   localparam logic [1:0] PULSE_MARK = 2'h1;
   localparam logic [1:0] PULSE_VIOL = 2'h2;
endpackage

// ---- logic/e1ts_ctrl.sv ----
// e1 timeslot 16 signalling, backplane enables, line coding and loopback control
`timescale 1ns/1ps
`default_nettype none
module e1ts_ctrl
   import e1ts_pkg::*;
(
   input wire logic sys_clk, // system clock, 25 MHz
   input wire logic rst, // asynchronous reset, active high
   input wire logic host_cs, // host select
   input wire logic host_wr, // host write strobe
   input wire logic host_rd, // host read strobe
   input wire logic [7:0] host_addr, // host register address
   input wire logic [7:0] host_wdata, // host write data
   output logic [7:0] host_rdata, // host read data
   input wire logic automatic_remote_mf_alarm, // host alarm bit is used when high
   input wire logic mf_align_lost, // receive framer reports multiframe loss
   input wire logic serial_data_in, // backplane transmit data pin
   input wire logic signalling_stream_in, // backplane transmit signalling pin
   output logic serial_data_out, // backplane receive data pin
   output logic serial_data_out_oe, // data pin driven when high
   output logic signalling_stream_out, // backplane receive signalling pin
   output logic signalling_stream_out_oe, // signalling pin driven when high
   output logic tx_line_pos, // positive line pulse
   output logic tx_line_neg, // negative line pulse
   input wire logic rx_line_pos, // received positive pulse
   input wire logic rx_line_neg, // received negative pulse
   output logic bit_strobe, // one cycle per line bit
   output logic [4:0] timeslot, // current timeslot
   output logic [3:0] frame // frame within the signalling multiframe
);

   typedef struct packed {
      logic [14:0] div_acc;
      logic bit_en;
      logic [7:0] bit_cnt;
      logic [3:0] frame_cnt;
      logic [7:0] mf_word;
      logic [7:0] sig_ctrl;
      logic [7:0] code_ctrl;
      logic [7:0] rdata;
      logic [2:0] sdi_sync;
      logic [2:0] csi_sync;
      logic [2:0] rxp_sync;
      logic [2:0] rxn_sync;
      logic sdi;
      logic csi;
      logic rxp;
      logic rxn;
      logic [7:0] csi_sr;
      logic [31:0][3:0] tx_sig_mem;
      logic [3:0][1:0] enc_pipe;
      logic [1:0] enc_zeros;
      logic enc_odd;
      logic enc_last;
      logic tx_pos;
      logic tx_neg;
      logic dec_last;
      logic [3:0] dec_pipe;
      logic sdo;
      logic cso;
      logic [7:0] rx_sr;
      logic [31:0][3:0] rx_stable;
      logic [31:0][3:0] rx_cand;
      logic [31:0][2:0] rx_cnt;
   } e1ts_state_type;

   e1ts_state_type st;
   e1ts_state_type next_st;

   // next state of the whole block
   always_comb begin
      logic [14:0] acc_sum;
      logic [4:0] ts;
      logic [2:0] bitn;
      logic [7:0] mf_byte;
      logic [7:0] cas_byte;
      logic [7:0] out_byte;
      logic tx_bit;
      logic [1:0] oldest;
      logic pol;
      logic rp;
      logic rn;
      logic pulse;
      logic viol;
      logic rx_bit;
      logic [7:0] rx_byte;
      logic [4:0] idx;
      logic [3:0] nib;
      acc_sum = '0;
      ts = '0;
      bitn = '0;
      mf_byte = '0;
      cas_byte = '0;
      out_byte = '0;
      tx_bit = 1'b0;
      oldest = PULSE_ZERO;
      pol = 1'b0;
      rp = 1'b0;
      rn = 1'b0;
      pulse = 1'b0;
      viol = 1'b0;
      rx_bit = 1'b0;
      rx_byte = '0;
      idx = '0;
      nib = '0;
      next_st = st;

      // line rate enable from a fractional divider
      acc_sum = st.div_acc + DIV_STEP;
      if (acc_sum >= DIV_MODULUS) begin
         next_st.div_acc = acc_sum - DIV_MODULUS;
         next_st.bit_en = 1'b1;
      end else begin
         next_st.div_acc = acc_sum;
         next_st.bit_en = 1'b0;
      end

      // pin synchronisers, a level is taken once stages two and three agree
      next_st.sdi_sync = {st.sdi_sync[1:0], serial_data_in};
      next_st.csi_sync = {st.csi_sync[1:0], signalling_stream_in};
      next_st.rxp_sync = {st.rxp_sync[1:0], rx_line_pos};
      next_st.rxn_sync = {st.rxn_sync[1:0], rx_line_neg};
      if (st.sdi_sync[1] == st.sdi_sync[2]) begin
         next_st.sdi = st.sdi_sync[2];
      end
      if (st.csi_sync[1] == st.csi_sync[2]) begin
         next_st.csi = st.csi_sync[2];
      end
      if (st.rxp_sync[1] == st.rxp_sync[2]) begin
         next_st.rxp = st.rxp_sync[2];
      end
      if (st.rxn_sync[1] == st.rxn_sync[2]) begin
         next_st.rxn = st.rxn_sync[2];
      end

      // host register writes and reads
      if (host_cs && host_wr) begin
         case (host_addr)
            ADDR_TX_TS16_MULTIFRAME_WORD: begin
               next_st.mf_word = host_wdata;
            end
            ADDR_INTERRUPT_SIGNALLING_CONTROL: begin
               next_st.sig_ctrl = host_wdata & MASK_INTERRUPT_SIGNALLING_CONTROL;
            end
            ADDR_CODING_LOOPBACK_CONTROL: begin
               next_st.code_ctrl = host_wdata & MASK_CODING_LOOPBACK_CONTROL;
            end
            default: begin
               next_st.mf_word = st.mf_word;
            end
         endcase
      end
      if (host_cs && host_rd) begin
         case (host_addr)
            ADDR_TX_TS16_MULTIFRAME_WORD: next_st.rdata = st.mf_word;
            ADDR_INTERRUPT_SIGNALLING_CONTROL: next_st.rdata = st.sig_ctrl;
            ADDR_CODING_LOOPBACK_CONTROL: next_st.rdata = st.code_ctrl;
            default: next_st.rdata = 8'h00;
         endcase
      end

      ts = st.bit_cnt[7:3];
      bitn = st.bit_cnt[2:0];

      if (st.bit_en) begin
         // capture the backplane signalling nibble of each timeslot
         next_st.csi_sr = {st.csi_sr[6:0], st.csi};
         if (bitn == 3'd7) begin
            if (st.sig_ctrl[SIG_UPPER_NIBBLE]) begin
               next_st.tx_sig_mem[ts] = st.csi_sr[6:3];
            end else begin
               next_st.tx_sig_mem[ts] = {st.csi_sr[2:0], st.csi};
            end
         end

         // transmit bit: frame zero of ts16 carries the multiframe word
         mf_byte = st.mf_word;
         if (!automatic_remote_mf_alarm) begin
            mf_byte[MF_REMOTE_ALARM] = mf_align_lost;
         end
         cas_byte = {st.tx_sig_mem[{1'b0, st.frame_cnt}], st.tx_sig_mem[{1'b1, st.frame_cnt}]};
         if (ts != SIG_TIMESLOT) begin
            tx_bit = st.sdi;
         end else if (st.frame_cnt == MF_FRAME_ZERO) begin
            tx_bit = mf_byte[~bitn];
         end else if (st.sig_ctrl[SIG_TX_CCS]) begin
            tx_bit = st.sdi;
         end else begin
            tx_bit = cas_byte[~bitn];
         end

         // encoder delay line, four zeros become 000V or B00V
         oldest = st.enc_pipe[3];
         next_st.enc_pipe = {st.enc_pipe[2:0], PULSE_ZERO};
         if (tx_bit) begin
            next_st.enc_pipe[0] = PULSE_MARK;
            next_st.enc_zeros = 2'd0;
            next_st.enc_odd = ~st.enc_odd;
         end else if (st.code_ctrl[CODE_TX_HDB3] && st.enc_zeros == 2'd3) begin
            next_st.enc_pipe[0] = PULSE_VIOL;
            if (!st.enc_odd) begin
               next_st.enc_pipe[3] = PULSE_MARK;
            end
            next_st.enc_zeros = 2'd0;
            next_st.enc_odd = 1'b0;
         end else begin
            next_st.enc_zeros = st.enc_zeros + 2'd1;
         end
         // marks alternate, a violation repeats the last polarity
         pol = st.enc_last;
         if (oldest == PULSE_MARK) begin
            pol = ~st.enc_last;
            next_st.enc_last = pol;
         end
         next_st.tx_pos = (oldest != PULSE_ZERO) && pol;
         next_st.tx_neg = (oldest != PULSE_ZERO) && !pol;

         // receive source: line pins or a loop from the transmit pulses
         if (st.code_ctrl[CODE_ANALOG_LOOP] || st.code_ctrl[CODE_DIGITAL_LOOP]) begin
            rp = st.tx_pos;
            rn = st.tx_neg;
         end else begin
            rp = st.rxp;
            rn = st.rxn;
         end

         // decoder: a same-polarity pulse removes itself and three bits before
         pulse = rp ^ rn;
         viol = st.code_ctrl[CODE_RX_HDB3] && pulse && (rp == st.dec_last);
         if (pulse) begin
            next_st.dec_last = rp;
         end
         rx_bit = st.dec_pipe[3];
         if (viol) begin
            next_st.dec_pipe = 4'h0;
         end else begin
            next_st.dec_pipe = {st.dec_pipe[2:0], pulse};
         end
         next_st.sdo = rx_bit;

         // received cas nibbles with the optional 14 ms filter
         next_st.rx_sr = {st.rx_sr[6:0], rx_bit};
         rx_byte = {st.rx_sr[6:0], rx_bit};
         if (ts == SIG_TIMESLOT && bitn == 3'd7 && st.frame_cnt != MF_FRAME_ZERO) begin
            for (int k = 0; k < 2; k++) begin
               idx = {k[0], st.frame_cnt};
               nib = (k == 0) ? rx_byte[7:4] : rx_byte[3:0];
               if (!st.sig_ctrl[SIG_FILTER_SEL]) begin
                  next_st.rx_stable[idx] = nib;
                  next_st.rx_cand[idx] = nib;
                  next_st.rx_cnt[idx] = 3'd0;
               end else if (nib != st.rx_cand[idx]) begin
                  next_st.rx_cand[idx] = nib;
                  next_st.rx_cnt[idx] = 3'd0;
               end else if (st.rx_cnt[idx] == SIG_FILTER_MF - 3'd1) begin
                  next_st.rx_stable[idx] = nib;
               end else begin
                  next_st.rx_cnt[idx] = st.rx_cnt[idx] + 3'd1;
               end
            end
         end

         // signalling stream out, nibble in the selected half
         if (st.sig_ctrl[SIG_UPPER_NIBBLE]) begin
            out_byte = {st.rx_stable[ts], 4'hF};
         end else begin
            out_byte = {4'hF, st.rx_stable[ts]};
         end
         next_st.cso = out_byte[~bitn];

         // frame timing
         next_st.bit_cnt = st.bit_cnt + 8'd1;
         if (st.bit_cnt == 8'hFF) begin
            next_st.frame_cnt = st.frame_cnt + 4'd1;
         end
      end
   end

   // state register
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         st <= '0;
         st.mf_word <= RST_TX_TS16_MULTIFRAME_WORD;
         st.sig_ctrl <= RST_INTERRUPT_SIGNALLING_CONTROL;
         st.code_ctrl <= RST_CODING_LOOPBACK_CONTROL;
         st.rx_stable <= '1;
         st.rx_cand <= '1;
      end else begin
         st <= next_st;
      end
   end

   // outputs
   assign host_rdata = st.rdata;
   assign serial_data_out = st.sdo;
   assign serial_data_out_oe = st.sig_ctrl[SIG_DATA_OUT_EN];
   assign signalling_stream_out = st.cso;
   assign signalling_stream_out_oe = st.sig_ctrl[SIG_STREAM_OUT_EN];
   assign tx_line_pos = st.tx_pos;
   assign tx_line_neg = st.tx_neg;
   assign bit_strobe = st.bit_en;
   assign timeslot = st.bit_cnt[7:3];
   assign frame = st.frame_cnt;

endmodule
`default_nettype wire

// ---- dv/e1ts_ctrl_sva.sv ----
// checker for the host port, output enables, bit strobe and line pulses
`timescale 1ns/1ps
`default_nettype none
module e1ts_ctrl_sva (
   input wire logic sys_clk, // clock
   input wire logic rst, // reset
   input wire logic host_cs, // select
   input wire logic host_wr, // write strobe
   input wire logic host_rd, // read strobe
   input wire logic [7:0] host_addr, // address
   input wire logic [7:0] host_wdata, // write data
   input wire logic [7:0] host_rdata, // read data
   input wire logic serial_data_out_oe, // data pin enable
   input wire logic signalling_stream_out_oe, // signalling pin enable
   input wire logic tx_line_pos, // pulse +
   input wire logic tx_line_neg, // pulse -
   input wire logic bit_strobe // bit strobe
);
   logic sig_wr;
   // a write to the signalling control word
   assign sig_wr = host_cs && host_wr && host_addr == 8'h14;
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (rst);
   // enables follow their bits, one cycle after the write
   property p_data_oe;
      sig_wr |=> serial_data_out_oe == $past(host_wdata[7]);
   endproperty
   a_data_oe: assert property (p_data_oe) else $error("data pin enable wrong");
   property p_sig_oe;
      sig_wr |=> signalling_stream_out_oe == $past(host_wdata[6]);
   endproperty
   a_sig_oe: assert property (p_sig_oe) else $error("signal pin enable wrong");
   property p_oe_hold;
      !sig_wr |=> $stable(serial_data_out_oe) && $stable(signalling_stream_out_oe);
   endproperty
   a_oe_hold: assert property (p_oe_hold) else $error("enable moved unwritten");
   // host reads
   property p_unmapped;
      host_cs && host_rd && (host_addr < 8'h13 || host_addr > 8'h15) |=> host_rdata == 8'h00;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
   property p_readback;
      sig_wr && !host_rd ##1 host_cs && host_rd && !host_wr && host_addr == 8'h14
         |=> host_rdata == ($past(host_wdata, 2) & 8'hF8);
   endproperty
   a_readback: assert property (p_readback) else $error("readback wrong");
   // line bit timing at 2048 of 25000 cycles
   property p_gap;
      bit_strobe |=> !bit_strobe [*8];
   endproperty
   a_gap: assert property (p_gap) else $error("strobes too close");
   property p_rate;
      bit_strobe |-> ##[12:13] bit_strobe;
   endproperty
   a_rate: assert property (p_rate) else $error("strobe late");
   // line pulses are bipolar and held for a bit period
   property p_no_both;
      !(tx_line_pos && tx_line_neg);
   endproperty
   a_no_both: assert property (p_no_both) else $error("both pulses high");
   property p_hold;
      $changed(tx_line_pos) || $changed(tx_line_neg) |-> $past(bit_strobe);
   endproperty
   a_hold: assert property (p_hold) else $error("pulse moved mid bit");
endmodule
bind e1ts_ctrl e1ts_ctrl_sva i_e1ts_ctrl_sva (.sys_clk, .rst, .host_cs, .host_wr, .host_rd,
   .host_addr, .host_wdata, .host_rdata, .serial_data_out_oe, .signalling_stream_out_oe,
   .tx_line_pos, .tx_line_neg, .bit_strobe);
`default_nettype wire

// ---- dv/e1ts_line_model.sv ----
// remote line terminal: decodes ts16 bytes off the line and loops the line back
`timescale 1ns/1ps
`default_nettype none
module e1ts_line_model (
   input wire logic sys_clk, // clock
   input wire logic bit_strobe, // bit strobe
   input wire logic [4:0] timeslot, // slot of bit taken
   input wire logic [3:0] frame, // frame of bit taken
   input wire logic tx_line_pos, // pulse +
   input wire logic tx_line_neg, // pulse -
   input wire logic hdb3_on, // undo substitutions
   output logic rx_line_pos, // echoed pulse +
   output logic rx_line_neg, // echoed pulse -
   output logic byte_valid, // ts16 byte ready
   output logic [7:0] ts16_byte, // decoded byte
   output logic [3:0] byte_frame, // its frame
   output int viol_cnt // violations seen
);
   logic [11:0] tag_q [5];
   logic [12:0] win [4];
   logic [12:0] old;
   logic [4:0] last_ts = 5'h00;
   logic [2:0] idx = 3'h0;
   logic [1:0] pol;
   logic [1:0] last_pol = 2'h0;
   logic [6:0] shreg = 7'h00;
   logic viol;
   // the far end loops the line straight back
   assign rx_line_pos = tx_line_pos;
   assign rx_line_neg = tx_line_neg;
   // per bit: tag, decode, undo substitution, assemble ts16 bytes
   always @(posedge sys_clk) begin
      byte_valid <= 1'b0;
      if (bit_strobe) begin
         if (timeslot == last_ts) idx = idx + 3'd1;
         else idx = 3'd0;
         last_ts = timeslot;
         pol = {tx_line_pos, tx_line_neg};
         viol = ^pol && pol == last_pol;
         if (^pol) last_pol = pol;
         viol_cnt <= viol_cnt + int'(viol);
         old = win[0];
         win = '{win[1], win[2], win[3], {^pol, tag_q[0]}};
         if (viol && hdb3_on) begin
            foreach (win[i]) win[i][12] = 1'b0;
         end
         tag_q = '{tag_q[1], tag_q[2], tag_q[3], tag_q[4], {frame, timeslot, idx}};
         if (old[7:3] == 5'd16) begin
            if (old[2:0] == 3'd7) begin
               byte_valid <= 1'b1;
               ts16_byte <= {shreg, old[12]};
               byte_frame <= old[11:8];
            end
            shreg = {shreg[5:0], old[12]};
         end
      end
   end
endmodule
`default_nettype wire

// ---- dv/tb_e1ts_ctrl.sv ----
// testbench: registers, output enables and ts16 content on the line
`timescale 1ns/1ps
`default_nettype none
module tb_e1ts_ctrl;
   logic sys_clk = 1'b0, rst = 1'b1, host_cs = 1'b0, host_wr = 1'b0, host_rd = 1'b0;
   logic [7:0] host_addr = 8'h00, host_wdata = 8'h00, host_rdata, ts16_byte, a, d;
   logic automatic_remote_mf_alarm = 1'b0, mf_align_lost = 1'b0, hdb3_on = 1'b0;
   logic serial_data_in = 1'b0, signalling_stream_in = 1'b0, byte_valid;
   logic serial_data_out, serial_data_out_oe, signalling_stream_out, signalling_stream_out_oe;
   logic tx_line_pos, tx_line_neg, rx_line_pos, rx_line_neg, bit_strobe;
   logic [4:0] timeslot;
   logic [3:0] frame, byte_frame;
   logic [7:0] model [3];
   int miscompares = 0, num_checks = 0, cyc = 0, m = 0, seed = 31722, viol_cnt;
   e1ts_ctrl i_e1ts_ctrl (.sys_clk, .rst, .host_cs, .host_wr, .host_rd, .host_addr,
      .host_wdata, .host_rdata, .automatic_remote_mf_alarm, .mf_align_lost, .serial_data_in,
      .signalling_stream_in, .serial_data_out, .serial_data_out_oe, .signalling_stream_out,
      .signalling_stream_out_oe, .tx_line_pos, .tx_line_neg, .rx_line_pos, .rx_line_neg,
      .bit_strobe, .timeslot, .frame);
   e1ts_line_model i_e1ts_line_model (.sys_clk, .bit_strobe, .timeslot, .frame, .tx_line_pos,
      .tx_line_neg, .hdb3_on, .rx_line_pos, .rx_line_neg, .byte_valid, .ts16_byte,
      .byte_frame, .viol_cnt);
   // 25 MHz clock
   initial forever #20 sys_clk = ~sys_clk;
   task tally_and_finish;
      $display("checks %0d mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   task chk(input logic [7:0] seen, input logic [7:0] exp);
      num_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // one host cycle, driven just after the edge
   task bus(input logic c, w, r, input logic [7:0] ad, dt);
      @(posedge sys_clk);
      host_cs <= c;
      host_wr <= w;
      host_rd <= r;
      host_addr <= ad;
      host_wdata <= dt;
   endtask
   task wr(input logic [7:0] ad, dt);
      if (ad >= 8'h13 && ad <= 8'h15)
         model[ad - 8'h13] = dt & (ad == 8'h13 ? 8'hFF : ad == 8'h14 ? 8'hF8 : 8'hE8);
      bus(1'b1, 1'b1, 1'b0, ad, dt);
      bus(1'b0, 1'b0, 1'b0, ad, dt);
   endtask
   task rd(input logic [7:0] ad);
      bus(1'b1, 1'b0, 1'b1, ad, 8'h00);
      bus(1'b0, 1'b0, 1'b0, ad, 8'h00);
      #1;
      chk(host_rdata, (ad >= 8'h13 && ad <= 8'h15) ? model[ad - 8'h13] : 8'h00);
   endtask
   // multiframe word as it should leave on the line
   function automatic logic [7:0] mf_exp();
      mf_exp = model[0];
      if (!automatic_remote_mf_alarm) mf_exp[2] = mf_align_lost;
   endfunction
   // hang guard
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 100000) begin
         miscompares++;
         tally_and_finish();
      end
   end
   // main sequence
   initial begin
      model = '{8'h0F, 8'h00, 8'h00};
      repeat (8) @(posedge sys_clk);
      rst <= 1'b0;
      foreach (model[i]) rd(8'h13 + 8'(i));
      rd(8'h16);
      repeat (8) begin
         a = 8'h12 + 8'(($random(seed) & 7) % 5);
         d = 8'($random(seed));
         if (a == 8'h13) d[7:4] = 4'h0;
         wr(a, d);
         rd(a);
      end
      model[1] = 8'hC0;
      bus(1'b1, 1'b1, 1'b0, 8'h14, 8'hC7);
      bus(1'b1, 1'b0, 1'b1, 8'h14, 8'h00);
      bus(1'b0, 1'b0, 1'b0, 8'h14, 8'h00);
      #1;
      chk(host_rdata, 8'hC0);
      chk({6'h0, serial_data_out_oe, signalling_stream_out_oe}, 8'h03);
      @(posedge sys_clk);
      mf_align_lost <= 1'b1;
      signalling_stream_in <= 1'b1;
      wr(8'h13, 8'h02);
      wr(8'h14, 8'h00);
      wr(8'h15, 8'h00);
      #1;
      chk({6'h0, serial_data_out_oe, signalling_stream_out_oe}, 8'h00);
      while (m < 2 || byte_frame != 4'd8) begin
         @(posedge sys_clk);
         if (byte_valid === 1'b1) begin
            if (byte_frame == 4'd0) m++;
            if (byte_frame == 4'd0) chk(ts16_byte, mf_exp());
            else if (m == 2 || byte_frame > 4'd1)
               chk(ts16_byte, {8{model[1][5] ? serial_data_in : signalling_stream_in}});
            if (m == 1 && byte_frame == 4'd0) chk(8'(viol_cnt), 8'h00);
            if (m == 1 && byte_frame == 4'd15) begin
               automatic_remote_mf_alarm <= 1'b1;
               hdb3_on <= 1'b1;
               wr(8'h13, 8'h0B);
               wr(8'h14, 8'h28);
               wr(8'h15, 8'hA0);
            end
         end
      end
      chk(8'(viol_cnt != 0), 8'h01);
      tally_and_finish();
   end
endmodule
`default_nettype wire
